/* File: design/lpdr_pkg.sv */
// Package: command encodings, timing constants and carrier types
`default_nettype none
package lpdr_pkg;
    localparam int BANKS    = 4;                  // Number of banks
    localparam int BA_W     = 2;                  // Bank address width
    localparam int ADDR_W   = 13;                 // Address width
    localparam int COL_W    = 9;                  // Column width
    localparam int DQ_W     = 16;                 // Data width
    localparam int AUTO_BIT = 10;                 // Address bit for auto close
    localparam int MR_SEL_BIT = 1;                // BA bit: 1 selects extended
    localparam logic [2:0] MR_BL_LSB = 3'h0;      // Burst length field pos
    localparam logic [3:0] MR_LAT_LSB = 4'h4;     // Read latency field pos
    localparam logic [ADDR_W-1:0] MR_RESET = 13'h0032; // BL4, latency 3
    localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000; // Extended reset
    localparam real  CLK_NS  = 10.0;              // Core clock period
    localparam real  T_RP_NS = 30.0;              // Precharge time
    localparam int   RP_CYC  = $rtoi((T_RP_NS + CLK_NS - 1.0) / CLK_NS);
    localparam logic [3:0] RP_CNT = 4'(RP_CYC);   // Precharge cycles

    // Command encodings on {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        CMD_MRS  = 3'h0,
        CMD_REF  = 3'h1,
        CMD_PRE  = 3'h2,
        CMD_ACT  = 3'h3,
        CMD_WR   = 3'h4,
        CMD_RD   = 3'h5,
        CMD_BT   = 3'h6,
        CMD_NOP  = 3'h7
    } lpdr_cmd_type;

    // Bank states
    typedef enum logic [1:0] {
        BK_IDLE   = 2'h0,
        BK_ACTIVE = 2'h1,
        BK_CLOSE  = 2'h2
    } lpdr_bank_type;

    // Command bus carrier
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } lpdr_cmd_bus_type;

    // Read request crossing into the link domain
    typedef struct packed {
        logic [2:0]        beats;   // Element pairs minus one
        logic              lat3;    // Latency 3 when set
        logic [DQ_W-1:0]   seed;    // Data seed from bank/row/column
    } lpdr_rd_req_type;

    // Data pins, a value and an enable for each two-way pin group
    typedef struct packed {
        logic [DQ_W-1:0]   dq;
        logic              dq_oe;
        logic              dqs;
        logic              dqs_oe;
    } lpdr_dq_out_type;
endpackage : lpdr_pkg
`default_nettype wire

/* File: design/lpdr_rd_out.sv */
// Link-domain read output engine: latency, strobe, data, tristate
`default_nettype none
module lpdr_rd_out
    import lpdr_pkg::*;
(
    input  wire logic                    lclk_i,      // Link clock
    input  wire logic                    lrst_i,      // Link-side reset
    input  wire logic [1:0]              req_tog_i,   // Request count, gray
    input  wire lpdr_pkg::lpdr_rd_req_type req_i,     // Request, held stable
    output var  lpdr_pkg::lpdr_dq_out_type pins_o     // Data pins
);
    // Gray count: two quick requests still leave a visible change
    logic [1:0]          sync1_reg, sync2_reg, seen_reg;
    logic [1:0]          sync1_next, sync2_next, seen_next;
    logic [2:0]          wait_reg, wait_next;     // Latency countdown
    logic [3:0]          left_reg, left_next;     // Elements left
    logic [DQ_W-1:0]     data_reg, data_next;     // Next data element
    logic                busy_reg, busy_next;     // Burst underway
    lpdr_dq_out_type     pins_reg, pins_next;
    logic                fire;

    // Next-state logic of the output engine
    always_comb begin
        sync1_next = req_tog_i;
        sync2_next = sync1_reg;
        seen_next  = sync2_reg;
        fire       = (sync2_reg != seen_reg);
        wait_next  = wait_reg;
        left_next  = left_reg;
        data_next  = data_reg;
        busy_next  = busy_reg;
        pins_next  = pins_reg;
        if (fire) begin
            // New read truncates or concatenates the current one
            wait_next = req_i.lat3 ? 3'h2 : 3'h1;
            left_next = 4'({req_i.beats, 1'b0}) + 4'h2;
            data_next = req_i.seed;
            busy_next = 1'b1;
        end else if (busy_reg && wait_reg != 3'h0) begin
            // Preamble: strobe driven low before data
            wait_next      = wait_reg - 3'h1;
            pins_next.dqs_oe = 1'b1;
            pins_next.dqs  = 1'b0;
        end else if (busy_reg && left_reg != 4'h0) begin
            // Edge-aligned data, strobe toggles per element
            pins_next.dq_oe  = 1'b1;
            pins_next.dqs_oe = 1'b1;
            pins_next.dq     = data_reg;
            pins_next.dqs    = ~left_reg[0];
            data_next        = data_reg + 16'h0001;
            left_next        = left_reg - 4'h1;
        end else begin
            // Burst over: release the bus to high impedance
            busy_next        = 1'b0;
            pins_next.dq_oe  = 1'b0;
            pins_next.dqs_oe = 1'b0;
            pins_next.dqs    = 1'b0;
        end
    end

    // Registers of the link domain
    always_ff @(posedge lclk_i) begin
        if (lrst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            seen_reg  <= 2'h0;
            wait_reg  <= 3'h0;
            left_reg  <= 4'h0;
            data_reg  <= 16'h0000;
            busy_reg  <= 1'b0;
            pins_reg  <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            seen_reg  <= seen_next;
            wait_reg  <= wait_next;
            left_reg  <= left_next;
            data_reg  <= data_next;
            busy_reg  <= busy_next;
            pins_reg  <= pins_next;
        end
    end

    assign pins_o = pins_reg;

    a_hiz_idle: assert property (@(posedge lclk_i) disable iff (lrst_i)
        !busy_reg |=> !pins_reg.dq_oe)
        else $error("data driven while idle");
    a_pre_low: assert property (@(posedge lclk_i) disable iff (lrst_i)
        $rose(pins_reg.dqs_oe) |-> !pins_reg.dqs)
        else $error("strobe preamble not low");
endmodule : lpdr_rd_out
`default_nettype wire

/* File: design/lpdr_core.sv */
// Command decode, per-bank row tracking and read launch
`default_nettype none
// Overview of operation
// - Chip select high: no new command taken
// - NOP: no new action, operations continue
// - Mode set loads main or extended register
// - ACTIVE opens row in addressed bank
// - Each bank keeps its own open row
// - Row open until precharge or auto close
// - READ bursts from active row, mode length
// - Address bit ten selects auto row close
// - Strobe driven with preamble, released right after the last element
// - Data edge-aligned, after latency two or three
// - Idle outputs return to high impedance
// - New READ concatenates or truncates burst
// - READ accepted on any following cycle
// - Burst terminate cuts read after latency
// - PRECHARGE may truncate read, then precharge time
// - Deselect and NOP act identically
// - PRECHARGE on closed bank is NOP
module lpdr_core
    import lpdr_pkg::*;
(
    input  wire logic                      clk_i,      // Core clock
    input  wire logic                      rst_i,      // Sync reset
    input  wire logic                      lclk_i,     // Link data clock
    input  wire logic                      lrst_i,     // Link-side reset
    input  wire lpdr_pkg::lpdr_cmd_bus_type cmd_i,     // Command bus
    output var  lpdr_pkg::lpdr_dq_out_type pins_o,     // Data pins
    output logic [ADDR_W-1:0]              mode_o,     // Mode register
    output logic [ADDR_W-1:0]              ext_mode_o, // Extended mode
    output logic [BANKS-1:0]               open_o      // Banks with open row
);
    import lpdr_pkg::*;

    lpdr_cmd_bus_type      cmd_reg;                     // Registered bus
    lpdr_cmd_type          cmd;                         // Decoded command
    logic [ADDR_W-1:0]     mode_reg, mode_next;
    logic [ADDR_W-1:0]     emr_reg, emr_next;
    lpdr_bank_type         st_reg [BANKS];              // Bank states
    lpdr_bank_type         st_next [BANKS];
    logic [ADDR_W-1:0]     row_reg [BANKS];             // Open rows
    logic [ADDR_W-1:0]     row_next [BANKS];
    logic [3:0]            tmr_reg [BANKS];             // Precharge timers
    logic [3:0]            tmr_next [BANKS];
    logic [3:0]            apc_reg [BANKS];             // Auto close countdown
    logic [3:0]            apc_next [BANKS];
    lpdr_rd_req_type       req_reg, req_next;           // Held read request
    logic [1:0]            tog_reg, tog_next;           // Request count, gray
    logic [3:0]            rd_left_reg, rd_left_next;   // Pairs still due
    logic [BA_W-1:0]       rd_bank_reg, rd_bank_next;   // Bank of last read
    logic [BANKS-1:0]      open_reg, open_next;
    logic [2:0]            bl_pairs;                    // Pairs minus one
    logic                  cmd_valid;                   // A command is taken
    logic [3:0]            lat;                         // Read latency

    // Command bus register; all decode reads this stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                         we_n: 1'b1, default: '0};
        end else begin
            cmd_reg <= cmd_i;
        end
    end

    // Decode; deselect folds into NOP
    always_comb begin
        cmd_valid = !cmd_reg.cs_n;
        cmd = cmd_valid ? lpdr_cmd_type'({cmd_reg.ras_n, cmd_reg.cas_n,
                                          cmd_reg.we_n}) : CMD_NOP;
        // Burst length code 1..3 gives 2,4,8 elements
        case (mode_reg[MR_BL_LSB +: 3])
            3'h1:    bl_pairs = 3'h0;
            3'h2:    bl_pairs = 3'h1;
            3'h3:    bl_pairs = 3'h3;
            default: bl_pairs = 3'h1;
        endcase
        lat = {1'b0, mode_reg[MR_LAT_LSB +: 3]};
    end

    // Next state for mode registers, banks and read launch
    always_comb begin
        mode_next    = mode_reg;
        emr_next     = emr_reg;
        req_next     = req_reg;
        tog_next     = tog_reg;
        rd_left_next = (rd_left_reg != 4'h0) ? rd_left_reg - 4'h1 : 4'h0;
        rd_bank_next = rd_bank_reg;
        for (int b = 0; b < BANKS; b++) begin
            st_next[b]  = st_reg[b];
            row_next[b] = row_reg[b];
            apc_next[b] = apc_reg[b];
            tmr_next[b] = (tmr_reg[b] != 4'h0) ? tmr_reg[b] - 4'h1 : 4'h0;
            // Precharge time elapsed: bank idle
            if (st_reg[b] == BK_CLOSE && tmr_reg[b] == 4'h1) begin
                st_next[b] = BK_IDLE;
            end
            // Auto close fires at end of burst
            if (apc_reg[b] == 4'h1) begin
                st_next[b]  = BK_CLOSE;
                tmr_next[b] = RP_CNT;
            end
            if (apc_reg[b] != 4'h0) begin
                apc_next[b] = apc_reg[b] - 4'h1;
            end
        end
        case (cmd)
            CMD_MRS: begin
                // Load selected mode register from address
                if (cmd_reg.ba[MR_SEL_BIT]) begin
                    emr_next = cmd_reg.addr;
                end else begin
                    mode_next = cmd_reg.addr;
                end
            end
            CMD_ACT: begin
                // Open row in addressed bank
                st_next[cmd_reg.ba]  = BK_ACTIVE;
                row_next[cmd_reg.ba] = cmd_reg.addr;
            end
            CMD_RD: begin
                // Start burst from open row, any cycle
                if (st_reg[cmd_reg.ba] == BK_ACTIVE) begin
                    req_next.beats = bl_pairs;
                    req_next.lat3  = (lat == 4'h3);
                    req_next.seed  = {cmd_reg.ba, row_reg[cmd_reg.ba][4:0],
                                      cmd_reg.addr[COL_W-1:0]};
                    // Gray step, so a later cut is not merged away unless four steps fall in one link cycle
                    tog_next       = {tog_reg[0], ~tog_reg[1]};
                    rd_left_next   = 4'({1'b0, bl_pairs}) + 4'h1;
                    rd_bank_next   = cmd_reg.ba;
                    if (cmd_reg.addr[AUTO_BIT]) begin
                        // Auto row close after the last pair
                        apc_next[cmd_reg.ba] = 4'({1'b0, bl_pairs}) + 4'h1;
                    end
                end
            end
            CMD_BT: begin
                // Truncate most recent read
                if (rd_left_reg != 4'h0) begin
                    // Pairs kept equal the cycles since the read
                    req_next.beats = 3'(4'({1'b0, bl_pairs}) + 4'h1
                                        - rd_left_reg);
                    tog_next       = {tog_reg[0], ~tog_reg[1]};
                    req_next.seed  = req_reg.seed;
                    rd_left_next   = 4'h0;
                end
            end
            CMD_PRE: begin
                // Closed or closing bank treats it as NOP
                if (st_reg[cmd_reg.ba] == BK_ACTIVE &&
                    apc_reg[cmd_reg.ba] == 4'h0) begin
                    st_next[cmd_reg.ba]  = BK_CLOSE;
                    tmr_next[cmd_reg.ba] = RP_CNT;
                    if (rd_left_reg != 4'h0 && rd_bank_reg == cmd_reg.ba) begin
                        // Precharge truncates running read
                        req_next.beats = 3'(4'({1'b0, bl_pairs}) + 4'h1
                                            - rd_left_reg);
                        tog_next       = {tog_reg[0], ~tog_reg[1]};
                        rd_left_next   = 4'h0;
                    end
                end
            end
            default: begin
                // NOP, deselect, write and refresh: no action
            end
        endcase
        for (int b = 0; b < BANKS; b++) begin
            open_next[b] = (st_next[b] == BK_ACTIVE);
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg    <= MR_RESET;
            emr_reg     <= EMR_RESET;
            req_reg     <= '0;
            tog_reg     <= 2'h0;
            rd_left_reg <= 4'h0;
            rd_bank_reg <= '0;
            open_reg    <= '0;
            for (int b = 0; b < BANKS; b++) begin
                st_reg[b]  <= BK_IDLE;
                row_reg[b] <= '0;
                tmr_reg[b] <= 4'h0;
                apc_reg[b] <= 4'h0;
            end
        end else begin
            mode_reg    <= mode_next;
            emr_reg     <= emr_next;
            req_reg     <= req_next;
            tog_reg     <= tog_next;
            rd_left_reg <= rd_left_next;
            rd_bank_reg <= rd_bank_next;
            open_reg    <= open_next;
            for (int b = 0; b < BANKS; b++) begin
                st_reg[b]  <= st_next[b];
                row_reg[b] <= row_next[b];
                tmr_reg[b] <= tmr_next[b];
                apc_reg[b] <= apc_next[b];
            end
        end
    end

    assign mode_o     = mode_reg;
    assign ext_mode_o = emr_reg;
    assign open_o     = open_reg;

    // Output engine on the link clock; request crosses by toggle
    lpdr_rd_out u_rd_out (
        .lclk_i    (lclk_i),
        .lrst_i    (lrst_i),
        .req_tog_i (tog_reg),
        .req_i     (req_reg),
        .pins_o    (pins_o)
    );

    // A deselected cycle with no read due launches no read request
    a_desel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_reg.cs_n && rd_left_reg == 4'h0 |=> $stable(tog_reg))
        else $error("command taken while deselected");
    a_mrs_load: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_MRS && !cmd_reg.ba[MR_SEL_BIT]
        |=> mode_reg == $past(cmd_reg.addr))
        else $error("mode register not loaded");
    a_act_open: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_ACT |=> open_reg[$past(cmd_reg.ba)])
        else $error("bank not opened");
    a_rd_launch: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_RD && st_reg[cmd_reg.ba] == BK_ACTIVE
        |=> tog_reg != $past(tog_reg))
        else $error("read not launched");
    a_pre_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_PRE && st_reg[cmd_reg.ba] == BK_IDLE
        |=> st_reg[$past(cmd_reg.ba)] == BK_IDLE)
        else $error("precharge on idle bank acted");
    a_nop_same: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_NOP |=> $stable(mode_reg) && $stable(emr_reg))
        else $error("NOP changed mode");
    a_pre_close: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_PRE && st_reg[cmd_reg.ba] == BK_ACTIVE
        && apc_reg[cmd_reg.ba] == 4'h0
        |=> !open_reg[$past(cmd_reg.ba)])
        else $error("precharge did not close row");
    a_bt_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd == CMD_BT |=> rd_left_reg == 4'h0)
        else $error("terminate did not stop read");
endmodule : lpdr_core
`default_nettype wire

/* File: tb/lpdr_ctrl_model.sv */
// Memory controller model that drives the command bus
`default_nettype none
module lpdr_ctrl_model
    import lpdr_pkg::*;
(
    input  wire logic                       clk_i, // Core clock
    output var  lpdr_pkg::lpdr_cmd_bus_type cmd_o  // Command bus
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle spacing covers row-to-column, row-to-row and mode delays
    localparam int GAP_CYC = 4;

    // Deselected at time zero
    initial begin
        cmd_o = '1;
    end

    // One command for one cycle, then deselect; released lines invert
    // so the device never sees a stale copy of the last command
    task automatic send(input lpdr_cmd_type c, input logic [1:0] b,
                        input logic [12:0] a, input int g);
        @(posedge clk_i);
        #1;
        cmd_o = {1'b0, c, b, a};
        @(posedge clk_i);
        #1;
        cmd_o = {1'b1, ~c, ~b, ~a};
        repeat (g) @(posedge clk_i);
    endtask
endmodule // lpdr_ctrl_model
`default_nettype wire

/* File: tb/lpdr_core_tb.sv */
// Self-checking bench for command decode and read bursts
`default_nettype none
module lpdr_core_tb;
    import lpdr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_i;      // Core clock
    logic              rst_i;      // Core reset
    logic              lclk_i;     // Link clock
    logic              lrst_i;     // Link reset
    lpdr_cmd_bus_type  cmd;        // Command bus from the model
    lpdr_dq_out_type   pins;       // Data pins
    logic [12:0]       mode;       // Mode register
    logic [12:0]       ext_mode;   // Extended mode register
    logic [3:0]        open_b;     // Open banks
    int                bad_count;  // Mismatches
    int                n_checks;   // Comparisons
    logic [15:0]       got[$];     // Collected burst elements
    int                pre;        // Preamble length in link cycles

    lpdr_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .lclk_i(lclk_i),
        .lrst_i(lrst_i), .cmd_i(cmd), .pins_o(pins), .mode_o(mode),
        .ext_mode_o(ext_mode), .open_o(open_b));
    lpdr_ctrl_model i_ctrl (.clk_i(clk_i), .cmd_o(cmd));

    // Core clock, 10 ns
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Link clock, 125 ns, offset in phase
    initial begin
        lclk_i = 1'b0;
        #7;
        forever #62.5 lclk_i = ~lclk_i;
    end
    // Link reset held over three link edges
    initial begin
        lrst_i = 1'b1;
        repeat (3) @(posedge lclk_i);
        #1 lrst_i = 1'b0;
    end

    // Counts one comparison, reports a mismatch
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // Expected first element of a burst
    function automatic logic [15:0] seed(logic [1:0] b, logic [4:0] r,
                                         logic [8:0] c);
        return {b, r, c};
    endfunction

    // Samples the pins mid link cycle until the burst ends
    task automatic grab();
        int w;
        got.delete();
        pre = 0;
        w = 0;
        while (pins.dqs_oe !== 1'b1 && w < 64) begin
            @(negedge lclk_i);
            w++;
        end
        while (pins.dqs_oe === 1'b1 && pins.dq_oe !== 1'b1 && w < 64) begin
            pre++;
            @(negedge lclk_i);
            w++;
        end
        while (pins.dq_oe === 1'b1 && w < 64) begin
            chk(pins.dqs === (got.size() % 2 == 0), "strobe phase");
            got.push_back(pins.dq);
            @(negedge lclk_i);
            w++;
        end
        chk(pins.dq_oe === 1'b0 && pins.dqs_oe === 1'b0, "not released");
    endtask

    // Compares a collected burst with its seed, length and preamble
    task automatic burst_is(input logic [15:0] s, input int n,
                            input int p);
        chk(got.size() == n, "burst length");
        chk(pre == p, "read latency");
        foreach (got[i]) chk(got[i] === s + 16'(i), "read data");
    endtask

    // Reset values of registers and pins
    task automatic t_reset();
        chk(mode === 13'h0032 && ext_mode === 13'h0000, "mode reset");
        chk(open_b === 4'h0 && pins.dq_oe === 1'b0, "idle reset");
    endtask

    // Mode loads; NOP and deselect with a mode code change nothing
    task automatic t_mode();
        i_ctrl.send(CMD_MRS, 2'h0, 13'h0022, 4);
        chk(mode === 13'h0022 && ext_mode === 13'h0000, "main mode");
        i_ctrl.send(CMD_MRS, 2'h2, 13'h0005, 4);
        chk(ext_mode === 13'h0005 && mode === 13'h0022, "ext mode");
        i_ctrl.send(CMD_NOP, 2'h0, 13'h1FFF, 4);
        chk(ext_mode === 13'h0005, "deselect acted");
    endtask

    // Two banks open, precharge of an idle bank ignored, one closed
    task automatic t_act();
        i_ctrl.send(CMD_ACT, 2'h0, 13'h0005, 4);
        i_ctrl.send(CMD_ACT, 2'h2, 13'h0009, 4);
        chk(open_b === 4'h5, "two banks open");
        i_ctrl.send(CMD_PRE, 2'h1, 13'h0000, 4);
        chk(open_b === 4'h5, "idle precharge");
        i_ctrl.send(CMD_PRE, 2'h2, 13'h0000, 4);
        chk(open_b === 4'h1, "precharge");
    endtask

    // Latency two, row stays open; then auto close shuts the row
    task automatic t_read_lat2();
        i_ctrl.send(CMD_RD, 2'h0, 13'h0010, 4);
        grab();
        burst_is(seed(2'h0, 5'h05, 9'h010), 4, 1);
        chk(open_b === 4'h1, "row kept");
        i_ctrl.send(CMD_RD, 2'h0, 13'h0420, 4);
        grab();
        burst_is(seed(2'h0, 5'h05, 9'h020), 4, 1);
        repeat (10) @(posedge clk_i);
        chk(open_b === 4'h0, "auto close");
    endtask

    // Burst of eight at latency three, then a restarting read
    task automatic t_read_lat3();
        i_ctrl.send(CMD_MRS, 2'h0, 13'h0033, 4);
        i_ctrl.send(CMD_ACT, 2'h1, 13'h0002, 4);
        i_ctrl.send(CMD_RD, 2'h1, 13'h0000, 4);
        grab();
        burst_is(seed(2'h1, 5'h02, 9'h000), 8, 2);
        i_ctrl.send(CMD_RD, 2'h1, 13'h0040, 12);
        i_ctrl.send(CMD_RD, 2'h1, 13'h0080, 0);
        grab();
        chk(got.size() >= 8, "restart length");
        chk(got[$] === seed(2'h1, 5'h02, 9'h080) + 16'h7, "restart");
    endtask

    // Terminate and precharge two cycles after a read keep two pairs
    task automatic t_cut();
        lpdr_cmd_type cut[2];
        cut[0] = CMD_BT;
        cut[1] = CMD_PRE;
        foreach (cut[k]) begin
            i_ctrl.send(CMD_RD, 2'h1, 13'h0100, 0);
            i_ctrl.send(cut[k], 2'h1, 13'h0000, 4);
            grab();
            burst_is(seed(2'h1, 5'h02, 9'h100), 4, 2);
            chk(open_b[1] === (k == 0), "bank state after cut");
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected 10 us or so of traffic
    initial begin
        #300us;
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_i);
        #1 rst_i = 1'b0;
        wait (lrst_i === 1'b0);
        repeat (2) @(posedge lclk_i);
        t_reset();
        t_mode();
        t_act();
        t_read_lat2();
        t_read_lat3();
        t_cut();
        close_out();
    end
endmodule // lpdr_core_tb
`default_nettype wire
